/* logic/ssss_port.sv */
// Purpose: serial port with slave-select synchronisation and sleep behaviour
// Assumes: link pins are sampled by clk; sleep_i comes from logic on clk
// Notes:   the select and clock pins pass two flops, so reactions lag by two cycles
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module ssss_port
  import ssss_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // wishbone slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic       wb_ack_o,
  // link pins
  input  wire ssss_pins_s pins_i,
  output      logic       sck_o,
  output      logic       sck_oe,
  output      logic       sdo_o,
  output      logic       sdo_oe,
  // power and interrupt
  input  wire logic       sleep_i,
  output      logic       irq_o,
  output      logic       wake_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    reg_hit = (adr == off);
  endfunction

  ssss_pins_s       pin_s;
  logic [7:0]       con1_q;
  logic [7:0]       con3_q;
  logic [1:0]       stat_q;
  logic [7:0]       buf_q;
  logic             bf_q;
  logic [7:0]       sr_q;
  logic [2:0]       cnt_q;
  logic             sck_q;
  logic             prev_q;
  logic             busy_q;
  logic [4:0]       tog_q;
  logic [7:0]       div_q;
  logic             sdo_q;
  logic             sdo_oe_q;
  logic             wake_q;
  logic             ack_q;
  logic [31:0]      dat_q;
  logic [EV_W-1:0]  mask_q;
  logic [EV_W-1:0]  ev_stat;
  logic [EV_W-1:0]  ev_set;
  logic             irq_q;
  logic             sck_oe_q;

  logic       en;
  logic       clock_polarity_bit;
  logic       cke;
  logic       boen;
  logic [3:0] mode;
  logic       master;
  logic       slave;
  logic       spi_rst;
  logic       lvl;
  logic       lead_edge;
  logic       trail_edge;
  logic       smp_edge;
  logic       out_edge;
  logic       byte_done;
  logic       req;
  logic       wr;
  logic       rd;
  logic       buf_wr;
  logic       wcol_ev;
  logic       ov_ev;
  logic       start;
  logic       frozen;

  assign en     = con1_q[CON1_EN];
  assign clock_polarity_bit    = con1_q[CON1_CKP];
  assign mode   = con1_q[3:0];
  assign cke    = stat_q[0];
  assign boen   = con3_q[CON3_BOEN];
  assign master = (mode == MODE_MASTER);
  assign slave  = (mode == MODE_SLAVE_SEL) || (mode == MODE_SLAVE_FREE);

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  ssss_sync u_sync (
    .clk    (clk),
    .nrst   (nrst),
    .pins_i (pins_i),
    .pins_o (pin_s)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign req    = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr     = req && wb_we_i && wb_sel_i[0];
  assign rd     = req && !wb_we_i;
  assign buf_wr = wr && reg_hit(wb_adr_i, ADR_BUF);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dat_q <= 32'h0;
    end else if (rd) begin
      dat_q <= 32'h0;
      if (reg_hit(wb_adr_i, ADR_BUF)) dat_q[7:0] <= buf_q;
      if (reg_hit(wb_adr_i, ADR_CON1)) dat_q[7:0] <= con1_q;
      if (reg_hit(wb_adr_i, ADR_CON3)) dat_q[7:0] <= con3_q;
      if (reg_hit(wb_adr_i, ADR_STAT)) dat_q[7:0] <= {stat_q, 5'h00, bf_q};
      if (reg_hit(wb_adr_i, ADR_ISTAT)) dat_q[EV_W-1:0] <= ev_stat;
      if (reg_hit(wb_adr_i, ADR_IMASK)) dat_q[EV_W-1:0] <= mask_q;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      con1_q <= CON1_RST;
    end else begin
      if (wr && reg_hit(wb_adr_i, ADR_CON1)) begin
        con1_q <= wb_dat_i[7:0];
      end
      // hardware set wins over a software clear
      if (wcol_ev) con1_q[CON1_WCOL] <= 1'b1;
      if (ov_ev) con1_q[CON1_OV] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      con3_q <= CON3_RST;
      stat_q <= STAT_RST;
      mask_q <= MASK_RST;
    end else begin
      if (wr && reg_hit(wb_adr_i, ADR_CON3)) con3_q <= wb_dat_i[7:0];
      if (wr && reg_hit(wb_adr_i, ADR_STAT)) stat_q <= wb_dat_i[STAT_SMP:STAT_CKE];
      if (wr && reg_hit(wb_adr_i, ADR_IMASK)) mask_q <= wb_dat_i[EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // clock edges
  // ----------------------------------------------------------------
  assign lvl        = master ? sck_q : pin_s.sck;
  assign lead_edge  = (lvl != prev_q) && (prev_q == clock_polarity_bit);
  assign trail_edge = (lvl != prev_q) && (prev_q != clock_polarity_bit);
  // sleep halts the master's own clock and its edge detector together
  assign frozen     = master && sleep_i;
  assign smp_edge   = en && !spi_rst && !frozen && (cke ? lead_edge : trail_edge);
  assign out_edge   = en && !spi_rst && !frozen && (cke ? trail_edge : lead_edge);
  assign spi_rst    = !en || !(master || slave)
                      || (mode == MODE_SLAVE_SEL && pin_s.ss_n);
  assign byte_done  = smp_edge && (cnt_q == 3'h7);
  assign wcol_ev    = buf_wr && (busy_q || cnt_q != 3'h0);
  assign ov_ev      = byte_done && bf_q && !boen;
  assign start      = buf_wr && !wcol_ev && en && master;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= 1'b0;
    end else if (!frozen) begin
      prev_q <= lvl;
    end
  end

  // ----------------------------------------------------------------
  // shift register and bit counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 3'h0;
    end else if (spi_rst) begin
      cnt_q <= 3'h0;
    end else if (smp_edge) begin
      cnt_q <= 3'(cnt_q + 3'h1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sr_q <= 8'h00;
    end else if (buf_wr && !wcol_ev) begin
      sr_q <= wb_dat_i[7:0];
    end else if (smp_edge) begin
      sr_q <= {sr_q[6:0], pin_s.sdi};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      buf_q <= BUF_RST;
    end else if (buf_wr && !wcol_ev) begin
      buf_q <= wb_dat_i[7:0];
    end else if (byte_done && !ov_ev) begin
      buf_q <= {sr_q[6:0], pin_s.sdi};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bf_q <= 1'b0;
    end else if (byte_done) begin
      bf_q <= 1'b1;
    end else if (rd && reg_hit(wb_adr_i, ADR_BUF)) begin
      bf_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // data output and its drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sdo_q <= 1'b0;
    end else if (buf_wr && !wcol_ev) begin
      sdo_q <= wb_dat_i[7];
    end else if (out_edge) begin
      sdo_q <= sr_q[7];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sdo_oe_q <= 1'b0;
    end else if (mode == MODE_SLAVE_SEL) begin
      sdo_oe_q <= en && !pin_s.ss_n;
    end else begin
      sdo_oe_q <= en && (master || slave);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_oe_q <= 1'b0;
    end else begin
      sck_oe_q <= en && master;
    end
  end

  // ----------------------------------------------------------------
  // master clock generator
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      tog_q  <= 5'h00;
      div_q  <= 8'h00;
      sck_q  <= 1'b0;
    end else if (!en || !master) begin
      busy_q <= 1'b0;
      tog_q  <= 5'h00;
      div_q  <= 8'h00;
      sck_q  <= clock_polarity_bit;
    end else if (start) begin
      busy_q <= 1'b1;
      tog_q  <= 5'h00;
      div_q  <= 8'h00;
    end else if (busy_q && !sleep_i) begin
      if (div_q == 8'(SCK_HALF_CYC - 1)) begin
        div_q <= 8'h00;
        sck_q <= !sck_q;
        tog_q <= 5'(tog_q + 5'h01);
        if (tog_q == 5'(BIT_TOGGLES - 1)) busy_q <= 1'b0;
      end else begin
        div_q <= 8'(div_q + 8'h01);
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt and wake
  // ----------------------------------------------------------------
  assign ev_set = {wcol_ev, ov_ev, byte_done};

  ssss_irq u_irq (
    .clk    (clk),
    .nrst   (nrst),
    .set_i  (ev_set),
    .clr_i  (rd && reg_hit(wb_adr_i, ADR_ISTAT)),
    .mask_i (mask_q),
    .stat_q (ev_stat),
    .irq_q  (irq_q)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= sleep_i && ev_stat[EV_BYTE] && mask_q[EV_BYTE];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign sck_o    = sck_q;
  assign sck_oe   = sck_oe_q;
  assign sdo_o    = sdo_q;
  assign sdo_oe   = sdo_oe_q;
  assign irq_o    = irq_q;
  assign wake_o   = wake_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  ss_realign_a: assert property ((mode == MODE_SLAVE_SEL) && pin_s.ss_n |=> cnt_q == 3'h0)
    else $error("bit counter not cleared by high select");
  mode_gate_a: assert property (en && mode == MODE_SLAVE_FREE && pin_s.ss_n && smp_edge |=> cnt_q == 3'($past(cnt_q) + 3'h1))
    else $error("select acted outside select-control mode");
  drive_low_a: assert property (en && mode == MODE_SLAVE_SEL && !pin_s.ss_n |=> sdo_oe)
    else $error("data output not driven with select low");
  float_high_a: assert property (mode == MODE_SLAVE_SEL && $rose(pin_s.ss_n) |=> !sdo_oe)
    else $error("data output still driven after select high");
  ss_reset_a: assert property (mode == MODE_SLAVE_SEL && pin_s.ss_n |-> !smp_edge && !byte_done)
    else $error("serial logic active while select high");
  en_clear_a: assert property (!en |=> cnt_q == 3'h0 && !busy_q)
    else $error("disable did not clear counter");
  sleep_freeze_a: assert property (master && busy_q && sleep_i && !start |=> $stable(sck_q) && $stable(cnt_q))
    else $error("master transfer moved during sleep");
  slave_sleep_a: assert property (slave && sleep_i && smp_edge && cnt_q != 3'h7 |=> cnt_q == 3'($past(cnt_q) + 3'h1))
    else $error("slave stopped shifting during sleep");
  wake_byte_a: assert property (byte_done && mask_q[EV_BYTE] && sleep_i ##1 sleep_i |-> ##1 wake_o && irq_o)
    else $error("slave byte did not wake");
  msb_first_a: assert property (byte_done && !bf_q |=> buf_q == {$past(sr_q[6:0]), $past(pin_s.sdi)} && bf_q)
    else $error("received byte not buffered msb first");
  free_drive_a: assert property (en && mode == MODE_SLAVE_FREE |=> sdo_oe)
    else $error("output not driven without select control");

  byte_rx_c: cover property (slave && byte_done);
  abort_mid_c: cover property (mode == MODE_SLAVE_SEL && $rose(pin_s.ss_n) && cnt_q != 3'h0);
  master_done_c: cover property (master && $fell(busy_q));
  wcol_c: cover property (wcol_ev);

endmodule // ssss_port

/* include/ssss_pkg.sv */
// Purpose: shared constants and types of the slave-select synchronised serial port
// Assumes: 125 MHz system clock, classic Wishbone register access
// Notes:   all offsets are byte addresses of aligned 32-bit words
package ssss_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_BUF   = 8'h00;
  localparam logic [7:0] ADR_CON1  = 8'h04;
  localparam logic [7:0] ADR_CON3  = 8'h08;
  localparam logic [7:0] ADR_STAT  = 8'h0c;
  localparam logic [7:0] ADR_ISTAT = 8'h10;
  localparam logic [7:0] ADR_IMASK = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CON1_WCOL = 7;
  localparam int CON1_OV   = 6;
  localparam int CON1_EN   = 5;
  localparam int CON1_CKP  = 4;
  localparam int CON3_BOEN = 4;
  localparam int STAT_SMP  = 7;
  localparam int STAT_CKE  = 6;
  localparam int STAT_BF   = 0;
  localparam int EV_BYTE   = 0;
  localparam int EV_OV     = 1;
  localparam int EV_WCOL   = 2;
  localparam int EV_W      = 3;

  // ----------------------------------------------------------------
  // port operating modes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_MASTER     = 4'h0;
  localparam logic [3:0] MODE_SLAVE_SEL  = 4'h4;
  localparam logic [3:0] MODE_SLAVE_FREE = 4'h5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]      CON1_RST = 8'h00;
  localparam logic [7:0]      CON3_RST = 8'h00;
  localparam logic [1:0]      STAT_RST = 2'h0;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;
  localparam logic [7:0]      BUF_RST  = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SCK_HALF_NS   = 16;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BIT_TOGGLES   = 16;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sck;
    logic ss_n;
    logic sdi;
  } ssss_pins_s;

endpackage

/* logic/ssss_sync.sv */
// Purpose: two-flop synchroniser for the link pins
// Assumes: inputs are asynchronous to clk
// Notes:   only the second stage is visible outside
`timescale 1ns/1ps
module ssss_sync
  import ssss_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // pins
  input  wire ssss_pins_s pins_i,
  output      ssss_pins_s pins_o
);

  // ----------------------------------------------------------------
  // per-bit two-stage chain
  // ----------------------------------------------------------------
  logic [2:0] meta_q;
  logic [2:0] sync_q;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_bit
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta_q[i] <= 1'b1;
          sync_q[i] <= 1'b1;
        end else begin
          meta_q[i] <= pins_i[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign pins_o = sync_q;

endmodule // ssss_sync

/* logic/ssss_irq.sv */
// Purpose: sticky event status, mask gating, level interrupt
// Assumes: clr_i is a one-cycle pulse from a status read
// Notes:   a set in the cycle of the clear wins
`timescale 1ns/1ps
module ssss_irq
  import ssss_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            nrst,
  // events and control
  input  wire logic [EV_W-1:0] set_i,
  input  wire logic            clr_i,
  input  wire logic [EV_W-1:0] mask_i,
  // state
  output      logic [EV_W-1:0] stat_q,
  output      logic            irq_q
);

  // ----------------------------------------------------------------
  // status and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (clr_i ? '0 : stat_q) | set_i;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((clr_i ? '0 : stat_q) | set_i) & mask_i);
    end
  end

endmodule // ssss_irq

/* dv/ssss_spi_master.sv */
// Purpose: behavioural external master of the serial link
// Assumes: clock polarity 0, link period 160 ns
// Notes:   data changes between edges, so either clock-edge setting samples it stable
`timescale 1ns/1ps
module ssss_spi_master
  import ssss_pkg::*;
(
  // link pins
  output ssss_pins_s pins
);
  // --------------------------------------------------------------
  // idle levels: select high, clock parked low
  // --------------------------------------------------------------
  initial begin
    pins = '{sck: 1'b0, ss_n: 1'b1, sdi: 1'b1};
  end

  task automatic sel(input logic lvl);
    // odd offset keeps pin changes away from the bench clock's rising edge
    #42 pins.ss_n = lvl;
    #40;
  endtask

  // clock stands still outside frames; released data line toggles
  task automatic send(input logic [7:0] val, input int nbits);
    #2;
    for (int i = 7; i > 7 - nbits; i--) begin
      pins.sdi = val[i];
      #40 pins.sck = 1'b1;
      #80 pins.sck = 1'b0;
      #40;
    end
    pins.sdi = ~pins.sdi;
  endtask
endmodule // ssss_spi_master

/* dv/ssss_port_test.sv */
// Purpose: self-checking bench of the serial port
// Assumes: 125 MHz clock, classic single Wishbone cycles
// Notes:   link master runs on its own unrelated timing
`timescale 1ns/1ps
module ssss_port_test
  import ssss_pkg::*;
;
  logic        clk;
  logic        nrst;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [3:0]  wb_sel;
  logic [7:0]  wb_adr;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        sck_o;
  logic        sck_oe;
  logic        sdo_oe;
  logic        sdo;
  logic        sleep;
  logic        irq;
  logic        wake;
  logic        s;
  ssss_pins_s  pins;
  int          fails;
  int          tests_run;
  int          cycles;

  ssss_spi_master i_mst (.pins(pins));

  ssss_port i_dut (
    .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .pins_i(pins), .sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo),
    .sdo_oe(sdo_oe), .sleep_i(sleep), .irq_o(irq), .wake_o(wake)
  );

  always #4 clk = ~clk;

  task automatic end_sim();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // --------------------------------------------------------------
  // bus cycle: hold request until ack is sampled high
  // --------------------------------------------------------------
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                          output logic [7:0] rd);
    @(posedge clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_sel  <= 4'h1;
    wb_adr  <= adr;
    wb_wdat <= {24'h0, wd};
    // ack ends this wait; if it never comes, only the bench watchdog does
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    wb_sel <= 4'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    logic [7:0] rd;
    wb_cycle(1'b1, adr, wd, rd);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp, input string name);
    logic [7:0] rd;
    wb_cycle(1'b0, adr, 8'h00, rd);
    check(name, rd, exp);
  endtask

  task automatic xfer(input logic [7:0] v, input int nbits, input logic use_sel);
    if (use_sel) i_mst.sel(1'b0);
    i_mst.send(v, nbits);
    if (use_sel) i_mst.sel(1'b1);
    repeat (6) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0; nrst = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_sel = 4'h0;
    wb_adr = 8'h00; wb_wdat = 32'h0; sleep = 1'b0;
    fails = 0; tests_run = 0; cycles = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    // ------------------------------------------------------------
    // reset values and unmapped place
    // ------------------------------------------------------------
    rd_chk(ADR_CON1, CON1_RST, "con1");
    rd_chk(ADR_CON3, CON3_RST, "con3");
    rd_chk(ADR_STAT, {STAT_RST, 6'h00}, "stat");
    rd_chk(ADR_ISTAT, 8'h00, "istat");
    rd_chk(ADR_IMASK, {5'h00, MASK_RST}, "imask");
    rd_chk(ADR_BUF, BUF_RST, "buf");
    rd_chk(8'h18, 8'h00, "unmapped");
    // ------------------------------------------------------------
    // slave with select: drive, float, byte, flags
    // ------------------------------------------------------------
    wr(ADR_IMASK, 8'h01);
    wr(ADR_CON1, {4'h2, MODE_SLAVE_SEL});
    rd_chk(ADR_CON1, {4'h2, MODE_SLAVE_SEL}, "con1 rw");
    i_mst.sel(1'b0);
    repeat (4) @(posedge clk);
    check("sdo_oe low sel", {7'h0, sdo_oe}, 8'h01);
    i_mst.send(8'ha5, 8);
    i_mst.sel(1'b1);
    check("sdo_oe high sel", {7'h0, sdo_oe}, 8'h00);
    repeat (4) @(posedge clk);
    check("irq byte", {7'h0, irq}, 8'h01);
    rd_chk(ADR_STAT, 8'h01, "full set");
    rd_chk(ADR_ISTAT, 8'h01, "istat byte");
    repeat (4) @(posedge clk);
    check("irq cleared", {7'h0, irq}, 8'h00);
    rd_chk(ADR_BUF, 8'ha5, "buf msb first");
    rd_chk(ADR_STAT, 8'h00, "full cleared");
    // partial byte discarded when select returns high
    xfer(8'hff, 3, 1'b1);
    xfer(8'h3c, 8, 1'b1);
    rd_chk(ADR_BUF, 8'h3c, "realign sel");
    rd_chk(ADR_ISTAT, 8'h01, "istat realign");
    // enable clear also zeroes the bit counter
    i_mst.sel(1'b0);
    i_mst.send(8'hff, 3);
    wr(ADR_CON1, {4'h0, MODE_SLAVE_SEL});
    wr(ADR_CON1, {4'h2, MODE_SLAVE_SEL});
    i_mst.send(8'h5a, 8);
    i_mst.sel(1'b1);
    repeat (6) @(posedge clk);
    rd_chk(ADR_BUF, 8'h5a, "realign en");
    // clock-edge bit set: select control on, sample-phase bit kept clear
    wr(ADR_STAT, 8'h40);
    rd_chk(ADR_STAT, 8'h40, "cke set");
    xfer(8'he7, 8, 1'b1);
    rd_chk(ADR_BUF, 8'he7, "cke byte");
    wr(ADR_STAT, 8'h00);
    // ------------------------------------------------------------
    // slave without select, and a mode that does not shift
    // ------------------------------------------------------------
    wr(ADR_CON1, {4'h2, MODE_SLAVE_FREE});
    check("sdo_oe free", {7'h0, sdo_oe}, 8'h01);
    xfer(8'hc3, 8, 1'b0);
    rd_chk(ADR_BUF, 8'hc3, "free byte");
    rd_chk(ADR_ISTAT, 8'h01, "istat free");
    wr(ADR_CON1, 8'h26);
    xfer(8'h81, 8, 1'b1);
    rd_chk(ADR_ISTAT, 8'h00, "no shift mode");
    // ------------------------------------------------------------
    // slave in sleep: receives and wakes only when unmasked
    // ------------------------------------------------------------
    wr(ADR_CON1, {4'h2, MODE_SLAVE_SEL});
    sleep <= 1'b1;
    xfer(8'h96, 8, 1'b1);
    check("wake", {7'h0, wake}, 8'h01);
    rd_chk(ADR_ISTAT, 8'h01, "istat sleep");
    rd_chk(ADR_BUF, 8'h96, "sleep byte");
    wr(ADR_IMASK, 8'h00);
    xfer(8'h69, 8, 1'b1);
    check("no wake", {7'h0, wake}, 8'h00);
    check("no irq", {7'h0, irq}, 8'h00);
    rd_chk(ADR_BUF, 8'h69, "masked byte");
    rd_chk(ADR_ISTAT, 8'h01, "istat masked");
    sleep <= 1'b0;
    // ------------------------------------------------------------
    // master frozen by sleep, resumes after
    // ------------------------------------------------------------
    wr(ADR_CON1, {4'h2, MODE_MASTER});
    check("sck_oe", {7'h0, sck_oe}, 8'h01);
    wr(ADR_BUF, 8'ha5);
    check("sdo msb", {7'h0, sdo}, 8'h01);
    repeat (6) @(posedge clk);
    sleep <= 1'b1;
    repeat (3) @(posedge clk);
    s = sck_o;
    repeat (30) @(posedge clk);
    check("sck frozen", {7'h0, sck_o}, {7'h0, s});
    rd_chk(ADR_ISTAT, 8'h00, "master held");
    // buffer write while the frozen transfer is pending collides
    wr(ADR_BUF, 8'h11);
    rd_chk(ADR_CON1, 8'ha0, "wcol set");
    sleep <= 1'b0;
    repeat (60) @(posedge clk);
    rd_chk(ADR_ISTAT, 8'h05, "master resumed");
    end_sim();
  end
endmodule // ssss_port_test
